// ==== rpfs_pkg.sv ====
// rpfs_pkg: register map, field positions, reset values and clock figures of the reset pin function select block.
// assumes one bus clock domain; all users import the whole package.
package rpfs_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam int NUM_PINS = 6;
  localparam int NUM_KEYPAD = 4;
  localparam int DEBUG_PIN = 4;
  localparam int SHARED_PIN = 5;

  localparam logic [ADDR_W-1:0] SYSTEM_OPTIONS_ONE_OFS = 4'h0;
  localparam logic [ADDR_W-1:0] IRQ_CTRL_OFS = 4'h1;
  localparam logic [ADDR_W-1:0] PULLUP_ENABLE_OFS = 4'h2;
  localparam logic [ADDR_W-1:0] KEYPAD_ENABLE_OFS = 4'h3;
  localparam logic [ADDR_W-1:0] KEYPAD_EDGE_OFS = 4'h4;
  localparam logic [ADDR_W-1:0] DEBUG_FORCE_RESET_REGISTER_OFS = 4'h5;
  localparam logic [ADDR_W-1:0] CLOCK_CTRL_OFS = 4'h6;
  localparam logic [ADDR_W-1:0] PIN_STATUS_OFS = 4'h7;

  // system_options_one fields
  localparam int RESET_PIN_ENABLE_BIT = 0;
  localparam int DEBUG_PIN_ENABLE_BIT = 1;
  // irq control fields
  localparam int IRQ_PIN_ENABLE_BIT = 0;
  localparam int IRQ_PULL_DISABLE_BIT = 1;
  localparam int IRQ_RISE_EDGE_BIT = 2;
  // debug force reset register field
  localparam int DEBUG_FORCE_RESET_BIT = 0;
  // clock control fields
  localparam int BUS_DIV_LSB = 0;
  localparam int BDC_ALT_CLK_BIT = 2;

  localparam logic DEBUG_PIN_ENABLE_RESET = 1'b1;
  localparam logic [2:0] IRQ_CTRL_RESET = 3'h0;
  localparam logic [NUM_PINS-1:0] PULLUP_ENABLE_RESET = 6'h00;
  localparam logic [NUM_KEYPAD-1:0] KEYPAD_RESET = 4'h0;
  localparam logic BDC_ALT_CLK_RESET = 1'b0;

  // internal clock source figures; bus clock = source / 2**div
  localparam int CLK_SRC_MHZ = 16;
  localparam int BUS_CLK_RESET_MHZ = 4;
  localparam int BUS_DIV_RATIO = CLK_SRC_MHZ / BUS_CLK_RESET_MHZ;
  localparam logic [1:0] BUS_DIV_RESET = 2'($clog2(BUS_DIV_RATIO));

  typedef enum logic [1:0] {FN_PORT, FN_RESET, FN_IRQ, FN_CAPTURE} rpfs_fn_t;
endpackage

// ==== rpfs_pull_if.sv ====
// rpfs_pull_if: pull requests and resolved pull devices passed between the mux and the pull resolver.
// assumes both ends sit on the same bus clock.
`timescale 1ns/10ps
`default_nettype none
interface rpfs_pull_if #(parameter int N = 6);
  logic [N-1:0] pull_req;
  logic [N-1:0] out_en;
  logic [N-1:0] to_down;
  logic [N-1:0] pull_en;
  logic [N-1:0] pull_dn;
  modport ctl (input pull_req, input out_en, input to_down, output pull_en, output pull_dn);
  modport top (output pull_req, output out_en, output to_down, input pull_en, input pull_dn);
endinterface
`default_nettype wire

// ==== rpfs_pull_ctl.sv ====
// rpfs_pull_ctl: per-pin pull device resolution, purely combinational.
// assumes the caller registers the results before they leave the block.
`timescale 1ns/10ps
`default_nettype none
module rpfs_pull_ctl #(
  parameter int N = 6
) (
  rpfs_pull_if.ctl pif
);
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_pin
      // a driven pin never keeps its pull device
      assign pif.pull_en[g] = pif.pull_req[g] & ~pif.out_en[g];
      assign pif.pull_dn[g] = pif.pull_req[g] & ~pif.out_en[g] & pif.to_down[g];
    end
  endgenerate
endmodule // rpfs_pull_ctl
`default_nettype wire

// ==== rpfs_reset_pin_mux.sv ====
// rpfs_reset_pin_mux: function select and pulls for the shared reset pin and the debug/mode-select pin.
// assumes i_por is high together with i_reset for a power-on reset, from logic on i_sys_clk;
// pin levels arrive asynchronously and are synchronised here.
//
// The implementer's own choices: the plain strobed port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// - all registers clocked by the bus clock
// - reset defaults give 4 MHz bus
// - user-mode power-on: shared pin is port input
// - software sets reset function, sticky until power-on
// - low on reset-function pin resets device
// - reset function turns on shared pin pullup
// - background power-on: shared pin is reset input
// - timer capture mode routes shared pin
// - pin reset only enters user mode
// - mode pin low at power-on or debug force reset enters background mode
// - irq function pull selectable up or down
// - debug enable turns on debug pin pullup
// - keypad edge select turns pullup into pulldown
// - each input pin has software pullup
// - low clock offered as debug clock
// - debug enable set on every reset
// - output pins lose their pullup
module rpfs_reset_pin_mux
  import rpfs_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic i_por,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [NUM_PINS-1:0] i_pin_in,
  input wire logic [NUM_PINS-1:0] i_pin_out_en,
  input wire logic i_port_a_bit_four_out,
  input wire logic i_timer_two_out,
  input wire logic i_timer_two_out_en,
  input wire logic i_timer_two_capture_mode,
  input wire logic i_bdc_out,
  input wire logic i_bdc_out_en,
  output logic [DATA_W-1:0] o_rdata,
  output logic o_ext_reset_req,
  output logic o_force_reset_req,
  output logic o_background_mode,
  output logic o_port_a_bit_five_in,
  output logic o_irq_in,
  output logic o_timer_two_capture_input,
  output logic o_debug_pin_in,
  output logic o_debug_pin_out,
  output logic o_debug_pin_oe_n,
  output logic [NUM_PINS-1:0] o_pullup_en,
  output logic [NUM_PINS-1:0] o_pulldown_en,
  output logic [1:0] o_bus_div_sel,
  output logic o_bdc_clk_low_sel
);

  // all state below is on i_sys_clk, the bus clock
  logic [NUM_PINS-1:0] pin_meta_reg;
  logic [NUM_PINS-1:0] pin_sync_reg;
  logic reset_pin_enable_reg;
  logic debug_pin_enable_reg;
  logic irq_pin_enable_reg;
  logic irq_pull_disable_reg;
  logic irq_rise_reg;
  logic [NUM_PINS-1:0] pullup_enable_reg;
  logic [NUM_KEYPAD-1:0] keypad_pin_enable_reg;
  logic [NUM_KEYPAD-1:0] keypad_edge_select_reg;
  logic [1:0] bus_div_reg;
  logic bdc_alt_clk_reg;
  logic force_pend_reg;
  logic reset_d_reg;
  logic background_reg;
  rpfs_fn_t fn_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic ext_reset_reg;
  logic port_in_reg;
  logic irq_in_reg;
  logic capture_in_reg;
  logic debug_in_reg;
  logic debug_out_reg;
  logic debug_oe_n_reg;
  logic [NUM_PINS-1:0] pullup_reg;
  logic [NUM_PINS-1:0] pulldown_reg;

  rpfs_pull_if #(.N(NUM_PINS)) pull_bus ();

  rpfs_pull_ctl #(.N(NUM_PINS)) u_pull (
    .pif(pull_bus)
  );

  // address decode
  wire wr_opts = i_wr & (i_addr == SYSTEM_OPTIONS_ONE_OFS);
  wire wr_irq = i_wr & (i_addr == IRQ_CTRL_OFS);
  wire wr_pue = i_wr & (i_addr == PULLUP_ENABLE_OFS);
  wire wr_kpe = i_wr & (i_addr == KEYPAD_ENABLE_OFS);
  wire wr_kpes = i_wr & (i_addr == KEYPAD_EDGE_OFS);
  wire wr_dfr = i_wr & (i_addr == DEBUG_FORCE_RESET_REGISTER_OFS);
  wire wr_clk = i_wr & (i_addr == CLOCK_CTRL_OFS);

  wire dbg_level = pin_sync_reg[DEBUG_PIN];
  wire shared_level = pin_sync_reg[SHARED_PIN];
  wire force_req = wr_dfr & i_wdata[DEBUG_FORCE_RESET_BIT];
  wire reset_release = reset_d_reg & ~i_reset;

  // mode entered at the end of this reset: only power-on or a debug force reset
  // may sample the mode pin; any other reset source lands in user mode
  wire enter_background = (i_por | force_pend_reg) & ~dbg_level;

  // shared pin function, reset function has priority
  rpfs_fn_t fn_next;
  assign fn_next = reset_pin_enable_reg ? FN_RESET :
                   irq_pin_enable_reg ? FN_IRQ :
                   i_timer_two_capture_mode ? FN_CAPTURE : FN_PORT;

  // debug pin: debug controller, then timer output, then port
  wire dbg_drive = debug_pin_enable_reg ? i_bdc_out_en :
                   i_timer_two_out_en ? 1'b1 : i_pin_out_en[DEBUG_PIN];
  wire dbg_value = debug_pin_enable_reg ? i_bdc_out :
                   i_timer_two_out_en ? i_timer_two_out : i_port_a_bit_four_out;

  // pull requests per pin
  genvar g;
  generate
    for (g = 0; g < NUM_PINS; g++) begin : g_req
      if (g < NUM_KEYPAD) begin : g_kp
        assign pull_bus.pull_req[g] = pullup_enable_reg[g];
        assign pull_bus.to_down[g] = keypad_pin_enable_reg[g] & keypad_edge_select_reg[g];
        assign pull_bus.out_en[g] = i_pin_out_en[g];
      end else if (g == DEBUG_PIN) begin : g_dbg
        assign pull_bus.pull_req[g] = debug_pin_enable_reg | pullup_enable_reg[g];
        assign pull_bus.to_down[g] = 1'b0;
        assign pull_bus.out_en[g] = dbg_drive;
      end else begin : g_shared
        // the shared pin is input only, so it never loses its pull to an output
        assign pull_bus.pull_req[g] = reset_pin_enable_reg ? 1'b1 :
                                      irq_pin_enable_reg ? ~irq_pull_disable_reg :
                                      pullup_enable_reg[g];
        assign pull_bus.to_down[g] = ~reset_pin_enable_reg & irq_pin_enable_reg & irq_rise_reg;
        assign pull_bus.out_en[g] = 1'b0;
      end
    end
  endgenerate

  // read mux; unmapped offsets and write-only bits read zero
  logic [DATA_W-1:0] rdata_next;
  always_comb begin
    rdata_next = '0;
    case (i_addr)
      SYSTEM_OPTIONS_ONE_OFS: begin
        rdata_next[RESET_PIN_ENABLE_BIT] = reset_pin_enable_reg;
        rdata_next[DEBUG_PIN_ENABLE_BIT] = debug_pin_enable_reg;
      end
      IRQ_CTRL_OFS: begin
        rdata_next[IRQ_PIN_ENABLE_BIT] = irq_pin_enable_reg;
        rdata_next[IRQ_PULL_DISABLE_BIT] = irq_pull_disable_reg;
        rdata_next[IRQ_RISE_EDGE_BIT] = irq_rise_reg;
      end
      PULLUP_ENABLE_OFS: begin
        rdata_next[NUM_PINS-1:0] = pullup_enable_reg;
      end
      KEYPAD_ENABLE_OFS: begin
        rdata_next[NUM_KEYPAD-1:0] = keypad_pin_enable_reg;
      end
      KEYPAD_EDGE_OFS: begin
        rdata_next[NUM_KEYPAD-1:0] = keypad_edge_select_reg;
      end
      CLOCK_CTRL_OFS: begin
        rdata_next[BUS_DIV_LSB+1:BUS_DIV_LSB] = bus_div_reg;
        rdata_next[BDC_ALT_CLK_BIT] = bdc_alt_clk_reg;
      end
      PIN_STATUS_OFS: begin
        rdata_next[0] = background_reg;
        rdata_next[1] = shared_level;
        rdata_next[2] = dbg_level;
        rdata_next[5:4] = fn_reg;
      end
      default: begin
        rdata_next = '0;
      end
    endcase
    if (!i_rd) begin
      rdata_next = '0;
    end
  end

  // pin synchronisers, never reset so they track the pins through reset
  always_ff @(posedge i_sys_clk) begin
    pin_meta_reg <= i_pin_in;
    pin_sync_reg <= pin_meta_reg;
  end

  // reset function: only power-on clears it, so a pin reset cannot undo itself
  always_ff @(posedge i_sys_clk) begin
    if (i_por) begin
      reset_pin_enable_reg <= ~dbg_level;
    end else if (wr_opts && i_wdata[RESET_PIN_ENABLE_BIT]) begin
      reset_pin_enable_reg <= 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      debug_pin_enable_reg <= DEBUG_PIN_ENABLE_RESET;
    end else if (wr_opts) begin
      debug_pin_enable_reg <= i_wdata[DEBUG_PIN_ENABLE_BIT];
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      {irq_rise_reg, irq_pull_disable_reg, irq_pin_enable_reg} <= IRQ_CTRL_RESET;
    end else if (wr_irq) begin
      irq_pin_enable_reg <= i_wdata[IRQ_PIN_ENABLE_BIT];
      irq_pull_disable_reg <= i_wdata[IRQ_PULL_DISABLE_BIT];
      irq_rise_reg <= i_wdata[IRQ_RISE_EDGE_BIT];
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      pullup_enable_reg <= PULLUP_ENABLE_RESET;
    end else if (wr_pue) begin
      pullup_enable_reg <= i_wdata[NUM_PINS-1:0];
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      keypad_pin_enable_reg <= KEYPAD_RESET;
      keypad_edge_select_reg <= KEYPAD_RESET;
    end else begin
      if (wr_kpe) begin
        keypad_pin_enable_reg <= i_wdata[NUM_KEYPAD-1:0];
      end
      if (wr_kpes) begin
        keypad_edge_select_reg <= i_wdata[NUM_KEYPAD-1:0];
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      bus_div_reg <= BUS_DIV_RESET;
      bdc_alt_clk_reg <= BDC_ALT_CLK_RESET;
    end else if (wr_clk) begin
      bus_div_reg <= i_wdata[BUS_DIV_LSB+1:BUS_DIV_LSB];
      bdc_alt_clk_reg <= i_wdata[BDC_ALT_CLK_BIT];
    end
  end

  // force request survives the reset it causes so the mode pin is sampled;
  // a new request in the release cycle wins over the clear
  always_ff @(posedge i_sys_clk) begin
    reset_d_reg <= i_reset;
    if (force_req && !i_reset) begin
      force_pend_reg <= 1'b1;
    end else if (reset_release || (i_por && i_reset)) begin
      force_pend_reg <= 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      background_reg <= enter_background;
    end
  end

  // function select forced to port only during a power-on reset
  always_ff @(posedge i_sys_clk) begin
    if (i_reset && i_por) begin
      fn_reg <= FN_PORT;
    end else begin
      fn_reg <= fn_next;
    end
  end

  // registered pin-facing outputs
  always_ff @(posedge i_sys_clk) begin
    if (i_reset && i_por) begin
      ext_reset_reg <= 1'b0;
      port_in_reg <= 1'b0;
      irq_in_reg <= 1'b0;
      capture_in_reg <= 1'b0;
    end else begin
      // a pin reset is requested only while the reset function owns the pin
      ext_reset_reg <= reset_pin_enable_reg & ~shared_level;
      port_in_reg <= shared_level;
      irq_in_reg <= (fn_next == FN_IRQ) & shared_level;
      capture_in_reg <= (fn_next == FN_CAPTURE) & shared_level;
    end
  end

  // debug pin released and high in reset, so the mode pin shows only the host
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      debug_in_reg <= 1'b1;
      debug_out_reg <= 1'b1;
      debug_oe_n_reg <= 1'b1;
    end else begin
      debug_in_reg <= dbg_level;
      debug_out_reg <= dbg_value;
      debug_oe_n_reg <= ~dbg_drive;
    end
  end

  // pulls held off in reset: inputs come out of reset high impedance
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      pullup_reg <= '0;
      pulldown_reg <= '0;
    end else begin
      pullup_reg <= pull_bus.pull_en & ~pull_bus.pull_dn;
      pulldown_reg <= pull_bus.pull_dn;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      rdata_reg <= '0;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign o_rdata = rdata_reg;
  assign o_ext_reset_req = ext_reset_reg;
  assign o_force_reset_req = force_pend_reg;
  assign o_background_mode = background_reg;
  assign o_port_a_bit_five_in = port_in_reg;
  assign o_irq_in = irq_in_reg;
  assign o_timer_two_capture_input = capture_in_reg;
  assign o_debug_pin_in = debug_in_reg;
  assign o_debug_pin_out = debug_out_reg;
  assign o_debug_pin_oe_n = debug_oe_n_reg;
  assign o_pullup_en = pullup_reg;
  assign o_pulldown_en = pulldown_reg;
  assign o_bus_div_sel = bus_div_reg;
  assign o_bdc_clk_low_sel = bdc_alt_clk_reg;

endmodule // rpfs_reset_pin_mux
`default_nettype wire

// ==== rpfs_reset_pin_mux_chk.sv ====
// rpfs_reset_pin_mux_chk: port-level assertions for the reset pin function select block.
// assumes one bus clock and a synchronous active-high reset; attached by bind.
`timescale 1ns/10ps
`default_nettype none
module rpfs_reset_pin_mux_chk
  import rpfs_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic i_por,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [NUM_PINS-1:0] i_pin_in,
  input wire logic [NUM_PINS-1:0] i_pin_out_en,
  input wire logic i_timer_two_capture_mode,
  input wire logic [DATA_W-1:0] o_rdata,
  input wire logic o_ext_reset_req,
  input wire logic o_force_reset_req,
  input wire logic o_background_mode,
  input wire logic o_timer_two_capture_input,
  input wire logic [NUM_PINS-1:0] o_pullup_en,
  input wire logic [1:0] o_bus_div_sel,
  input wire logic o_bdc_clk_low_sel
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);
  property p_rdata_idle;
    !($past(i_rd) && !$past(i_reset)) |-> o_rdata == '0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside its cycle");
  property p_out_no_pull;
    ($past(i_pin_out_en[NUM_KEYPAD-1:0]) & o_pullup_en[NUM_KEYPAD-1:0]) == '0;
  endproperty
  a_out_no_pull: assert property (p_out_no_pull) else $error("pullup on an output pin");
  property p_pin_reset_user;
    $fell(i_reset) && !$past(i_por) && !$past(o_force_reset_req) |-> !o_background_mode;
  endproperty
  a_pin_reset_user: assert property (p_pin_reset_user) else $error("plain reset entered background");
  property p_por_mode;
    $fell(i_reset) && $past(i_por) |-> o_background_mode == !$past(i_pin_in[DEBUG_PIN], 3);
  endproperty
  a_por_mode: assert property (p_por_mode) else $error("power-on mode not taken from mode pin");
  property p_ext_req_pin;
    o_ext_reset_req |-> !$past(i_pin_in[SHARED_PIN], 3);
  endproperty
  a_ext_req_pin: assert property (p_ext_req_pin) else $error("reset request without low pin");
  property p_capture;
    o_timer_two_capture_input |-> $past(i_timer_two_capture_mode) && $past(i_pin_in[SHARED_PIN], 3);
  endproperty
  a_capture: assert property (p_capture) else $error("capture input not routed from pin");
  property p_clock_defaults;
    $fell(i_reset) |-> o_bus_div_sel == BUS_DIV_RESET && !o_bdc_clk_low_sel;
  endproperty
  a_clock_defaults: assert property (p_clock_defaults) else $error("clock settings not at defaults");
  property p_force_req;
    $past(i_wr) && $past(i_addr) == DEBUG_FORCE_RESET_REGISTER_OFS && $past(i_wdata[DEBUG_FORCE_RESET_BIT])
      |-> o_force_reset_req;
  endproperty
  a_force_req: assert property (p_force_req) else $error("force write gave no reset request");
endmodule // rpfs_reset_pin_mux_chk
`default_nettype wire

// ==== rpfs_pin_host.sv ====
// rpfs_pin_host: external reset source and debug host on the shared pin and the mode-select pin.
// assumes commands from the bench change just after a rising clock edge.
`timescale 1ns/10ps
`default_nettype none
module rpfs_pin_host (
  input wire logic i_clk,
  input wire logic i_reset_low,
  input wire logic i_mode_low,
  input wire logic i_pu,
  input wire logic i_pd,
  input wire logic i_dbg_out,
  input wire logic i_dbg_oe_n,
  output logic o_shared,
  output logic o_mode
);
  initial o_shared = 1'b1;
  always @(posedge i_clk) begin
    if (i_reset_low) o_shared <= 1'b0;
    else if (i_pu) o_shared <= 1'b1;
    else if (i_pd) o_shared <= 1'b0;
    else o_shared <= ~o_shared; // undriven and unpulled: no level to trust
  end
  // the debug header keeps a pull-up on the mode line
  always_comb o_mode = i_mode_low ? 1'b0 : (i_dbg_oe_n ? 1'b1 : i_dbg_out);
endmodule // rpfs_pin_host
`default_nettype wire

// ==== testbench.sv ====
// testbench: self-checking bench for the reset pin function select block.
// assumes the pin host model and the checker are compiled beside it.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import rpfs_pkg::*;
  logic i_sys_clk = 1'b0, i_reset = 1'b1, i_por = 1'b1, i_wr = 1'b0, i_rd = 1'b0, i_timer_two_capture_mode = 1'b0;
  logic drv_low = 1'b0, mode_low = 1'b0, rd_seen = 1'b0, i_bdc_out_en = 1'b0, shared, mode;
  logic [ADDR_W-1:0] i_addr = '0;
  logic [DATA_W-1:0] i_wdata = '0, o_rdata;
  logic [NUM_PINS-1:0] i_pin_out_en = '0, o_pullup_en, o_pulldown_en;
  logic [31:0] rnd = '0;
  logic [15:0] e;
  logic [3:0] oe, kb;
  logic [1:0] o_bus_div_sel;
  logic o_ext_reset_req, o_force_reset_req, o_background_mode, o_port_a_bit_five_in, o_irq_in;
  logic o_timer_two_capture_input, o_debug_pin_in, o_debug_pin_out, o_debug_pin_oe_n, o_bdc_clk_low_sel;
  logic [15:0] exp_q[$];
  logic [7:0] irq_v[3] = '{8'h01, 8'h05, 8'h03};
  int seed = 74922, n_errors = 0, n_compared = 0, k;
  wire logic [NUM_PINS-1:0] i_pin_in = {shared, mode, rnd[3:0]};
  wire logic i_port_a_bit_four_out = rnd[4];
  wire logic i_timer_two_out = rnd[5];
  wire logic i_bdc_out = ~i_bdc_out_en;
  wire logic i_timer_two_out_en = 1'b0;

  rpfs_reset_pin_mux dut_u (.i_sys_clk, .i_reset, .i_por, .i_addr, .i_wdata, .i_wr, .i_rd, .i_pin_in, .i_pin_out_en,
    .i_port_a_bit_four_out, .i_timer_two_out, .i_timer_two_out_en, .i_timer_two_capture_mode, .i_bdc_out, .i_bdc_out_en,
    .o_rdata, .o_ext_reset_req, .o_force_reset_req, .o_background_mode, .o_port_a_bit_five_in, .o_irq_in,
    .o_timer_two_capture_input, .o_debug_pin_in, .o_debug_pin_out, .o_debug_pin_oe_n, .o_pullup_en, .o_pulldown_en,
    .o_bus_div_sel, .o_bdc_clk_low_sel);
  rpfs_pin_host host_u (.i_clk(i_sys_clk), .i_reset_low(drv_low), .i_mode_low(mode_low), .i_pu(o_pullup_en[SHARED_PIN]),
    .i_pd(o_pulldown_en[SHARED_PIN]), .i_dbg_out(o_debug_pin_out), .i_dbg_oe_n(o_debug_pin_oe_n), .o_shared(shared),
    .o_mode(mode));

  initial begin
    forever #25 i_sys_clk = ~i_sys_clk;
  end
  always @(posedge i_sys_clk) rnd <= $random(seed);

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_sys_clk);
    #1;
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge i_sys_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
  endtask
  // the read answer is checked by the monitor, one cycle after the strobe
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input logic [DATA_W-1:0] m);
    @(posedge i_sys_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    exp_q.push_back({m, d});
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
  endtask
  task automatic do_reset(input logic p);
    @(posedge i_sys_clk);
    i_reset <= 1'b1;
    i_por <= p;
    repeat (6) @(posedge i_sys_clk);
    i_reset <= 1'b0;
    i_por <= 1'b0;
    cyc(2);
  endtask
  task automatic stop_test;
    $display("compared %0d, errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  always @(posedge i_sys_clk) begin
    rd_seen <= i_rd && !i_reset;
    if (rd_seen) begin
      e = exp_q.pop_front();
      chk(o_rdata & e[15:8], e[7:0]);
    end
  end

  initial begin
    repeat (4000) @(posedge i_sys_clk);
    n_errors++;
    $display("Error %0t: timeout", $time);
    stop_test();
  end

  initial begin
    repeat (6) @(posedge i_sys_clk);
    i_reset <= 1'b0;
    i_por <= 1'b0;
    cyc(2);
    chk(o_background_mode, 0);
    chk(o_bus_div_sel, BUS_DIV_RESET);
    rd(SYSTEM_OPTIONS_ONE_OFS, 8'h02, 8'hff);
    rd(CLOCK_CTRL_OFS, 8'(BUS_DIV_RESET), 8'hff);
    rd(PIN_STATUS_OFS, 8'h00, 8'h31);
    wr(4'h9, 8'hff);
    rd(4'h9, 8'h00, 8'hff);
    rd(DEBUG_FORCE_RESET_REGISTER_OFS, 8'h00, 8'hff);
    wr(PULLUP_ENABLE_OFS, 8'h20);
    cyc(5);
    chk(o_port_a_bit_five_in, 1);
    chk(o_irq_in, 0);
    drv_low <= 1'b1;
    cyc(5);
    chk(o_port_a_bit_five_in, 0);
    $display("test 1 done");
    @(posedge i_sys_clk);
    i_timer_two_capture_mode <= 1'b1;
    cyc(5);
    chk(o_timer_two_capture_input, 0);
    drv_low <= 1'b0;
    cyc(5);
    chk(o_timer_two_capture_input, 1);
    rd(PIN_STATUS_OFS, 8'h30, 8'h30);
    wr(CLOCK_CTRL_OFS, 8'h06);
    cyc(2);
    chk(o_bdc_clk_low_sel, 1);
    wr(PULLUP_ENABLE_OFS, 8'h00);
    foreach (irq_v[j]) begin
      wr(IRQ_CTRL_OFS, irq_v[j]);
      cyc(5);
      chk(o_pullup_en[SHARED_PIN], j == 0);
      chk(o_pulldown_en[SHARED_PIN], j == 1);
      chk(o_timer_two_capture_input, 0);
      if (j < 2) chk(o_irq_in, j == 0);
    end
    wr(IRQ_CTRL_OFS, 8'h00);
    i_timer_two_capture_mode <= 1'b0;
    $display("test 2 done");
    wr(PULLUP_ENABLE_OFS, 8'h0f);
    wr(KEYPAD_ENABLE_OFS, 8'h0f);
    repeat (4) begin
      oe = rnd[11:8];
      kb = rnd[15:12];
      wr(KEYPAD_EDGE_OFS, {4'h0, kb});
      i_pin_out_en <= {2'b00, oe};
      cyc(2);
      chk(o_pullup_en[3:0], 4'(~oe & ~kb));
      chk(o_pulldown_en[3:0], 4'(~oe & kb));
    end
    wr(KEYPAD_ENABLE_OFS, 8'h00);
    i_pin_out_en <= '0;
    $display("test 3 done");
    cyc(2);
    chk(o_pullup_en[DEBUG_PIN], 1);
    chk(o_debug_pin_in, 1);
    @(posedge i_sys_clk);
    i_bdc_out_en <= 1'b1;
    cyc(4);
    chk(o_pullup_en[DEBUG_PIN], 0);
    chk({o_debug_pin_oe_n, o_debug_pin_out, o_debug_pin_in}, 0);
    wr(SYSTEM_OPTIONS_ONE_OFS, 8'h00);
    i_bdc_out_en <= 1'b0;
    cyc(2);
    chk(o_pullup_en[DEBUG_PIN], 0);
    wr(PULLUP_ENABLE_OFS, 8'h10);
    cyc(2);
    chk(o_pullup_en[DEBUG_PIN], 1);
    do_reset(0);
    rd(SYSTEM_OPTIONS_ONE_OFS, 8'h02, 8'hff);
    rd(PULLUP_ENABLE_OFS, 8'(PULLUP_ENABLE_RESET), 8'hff);
    $display("test 4 done");
    wr(SYSTEM_OPTIONS_ONE_OFS, 8'h03);
    wr(SYSTEM_OPTIONS_ONE_OFS, 8'h02);
    rd(SYSTEM_OPTIONS_ONE_OFS, 8'h03, 8'hff);
    rd(PIN_STATUS_OFS, 8'h10, 8'h30);
    cyc(2);
    chk(o_pullup_en[SHARED_PIN], 1);
    mode_low <= 1'b1;
    drv_low <= 1'b1;
    for (k = 0; k < 10 && o_ext_reset_req !== 1'b1; k++) cyc(1);
    chk(o_ext_reset_req, 1);
    drv_low <= 1'b0;
    do_reset(0);
    chk(o_background_mode, 0);
    rd(SYSTEM_OPTIONS_ONE_OFS, 8'h03, 8'hff);
    mode_low <= 1'b0;
    do_reset(1);
    chk(o_background_mode, 0);
    rd(SYSTEM_OPTIONS_ONE_OFS, 8'h02, 8'hff);
    $display("test 5 done");
    mode_low <= 1'b1;
    wr(DEBUG_FORCE_RESET_REGISTER_OFS, 8'h01);
    cyc(1);
    chk(o_force_reset_req, 1);
    do_reset(0);
    chk(o_background_mode, 1);
    chk(o_force_reset_req, 0);
    do_reset(1);
    chk(o_background_mode, 1);
    rd(SYSTEM_OPTIONS_ONE_OFS, 8'h03, 8'hff);
    rd(PIN_STATUS_OFS, 8'h11, 8'h31);
    cyc(3);
    $display("test 6 done");
    stop_test();
  end
endmodule // testbench

bind rpfs_reset_pin_mux rpfs_reset_pin_mux_chk chk_u (.i_sys_clk, .i_reset, .i_por, .i_addr, .i_wdata, .i_wr, .i_rd,
  .i_pin_in, .i_pin_out_en, .i_timer_two_capture_mode, .o_rdata, .o_ext_reset_req, .o_force_reset_req,
  .o_background_mode, .o_timer_two_capture_input, .o_pullup_en, .o_bus_div_sel, .o_bdc_clk_low_sel);
`default_nettype wire
